//--- rtl/ebps_pkg.sv
// shared constants for the external bus pin sharing block
package ebps_pkg;
    // pin slots in the packed pad vectors
    localparam int unsigned NUM_DATA     = 4;
    localparam int unsigned NUM_CS       = 6;
    localparam int unsigned NUM_PINS     = 1 + NUM_DATA + NUM_CS;
    localparam int unsigned SLOT_ADDR    = 0;
    localparam int unsigned SLOT_DATA    = 1;
    localparam int unsigned SLOT_CS      = SLOT_DATA + NUM_DATA;
    // bit positions inside the port registers
    localparam int unsigned PORT_B_BIT   = 4;
    localparam int unsigned PORT_F_BASE  = 0;
    localparam int unsigned PORT_D_BASE  = 0;
    localparam int unsigned PORT_W       = 8;
    // reset values
    localparam logic        RST_PU_ADDR  = 1'h1;
    localparam logic        RST_PER_ADDR = 1'h0;
    localparam logic [3:0]  RST_PU_DATA  = 4'hf;
    localparam logic [3:0]  RST_PER_DATA = 4'hf;
    localparam logic [5:0]  RST_PU_CS    = 6'h3f;
    localparam logic [5:0]  RST_PER_CS   = 6'h00;
    localparam logic        RST_CLK_SEL  = 1'h0;
    typedef struct packed {
        logic                pu_addr;
        logic                per_addr;
        logic [NUM_DATA-1:0] pu_data;
        logic [NUM_DATA-1:0] per_data;
        logic [NUM_CS-1:0]   pu_cs;
        logic [NUM_CS-1:0]   per_cs;
        logic                clk_sel;
    } ebps_state_t;
endpackage : ebps_pkg

//--- rtl/ebps_pad_cell.sv
// one shared pad: gpio or peripheral selection, drive and pull-up
`timescale 1ns/1ps
`default_nettype none
module ebps_pad_cell (
    input  wire logic periph_sel_in,
    input  wire logic gpio_out_in,
    input  wire logic gpio_dir_in,
    input  wire logic periph_out_in,
    input  wire logic periph_oe_in,
    input  wire logic pullup_en_in,
    output logic      pad_out,
    output logic      pad_oe_out,
    output logic      pad_pu_out
);
    // peripheral owns the pad when selected, gpio otherwise
    always_comb begin
        if (periph_sel_in) begin
            pad_out    = periph_out_in;
            pad_oe_out = periph_oe_in;
        end else begin
            pad_out    = gpio_out_in;
            pad_oe_out = gpio_dir_in;
        end
        // pull-up only while the pad is not driven
        pad_pu_out = pullup_en_in & ~pad_oe_out;
    end
endmodule : ebps_pad_cell
`default_nettype wire

//--- rtl/ebps_pin_mux.sv
// pin sharing for address line twenty, data lines 7-10, chip selects 2-7
// Function
// - every shared pin can be a gpio input or a gpio output.
// - after reset address line twenty pin is gpio input with pull-up.
// - clearing port b pull-up bit 4 removes address line twenty pull-up.
// - port b peripheral enable hands address line twenty pin to a peripheral.
// - clock output select picks address line twenty or prescaler clock.
// - idle bus tri-states address twenty unless drive bit or clock output select set.
// - data lines 7-10 come up as data bus after reset.
// - idle bus tri-states data lines 7-10 unless drive bit and data output enable both set.
// - clearing port f pull-up bit n removes pull-up of port f pin n.
// - chip selects 2-7 drive from memory interface, tri-state when idle unless drive bit set.
// - chip select pins come up as gpio inputs with pull-up.
// - clearing port d pull-up bit n removes pull-up of port d pin n.
`timescale 1ns/1ps
`default_nettype none
module ebps_pin_mux #(
    parameter int unsigned DATA_PINS = ebps_pkg::NUM_DATA,
    parameter int unsigned CS_PINS   = ebps_pkg::NUM_CS
) (
    input  wire logic                         clk_sys_in,
    input  wire logic                         sys_rst_in,
    input  wire logic                         clk_en_in,
    // register writes
    input  wire logic                         port_b_pullup_wr_in,
    input  wire logic                         port_b_periph_wr_in,
    input  wire logic [ebps_pkg::PORT_W-1:0]  port_b_data_in,
    input  wire logic                         port_f_pullup_wr_in,
    input  wire logic                         port_f_periph_wr_in,
    input  wire logic [ebps_pkg::PORT_W-1:0]  port_f_data_in,
    input  wire logic                         port_d_pullup_wr_in,
    input  wire logic                         port_d_periph_wr_in,
    input  wire logic [ebps_pkg::PORT_W-1:0]  port_d_data_in,
    input  wire logic                         clock_output_select_wr_in,
    input  wire logic                         clock_output_select_in,
    input  wire logic                         bus_drive_control_bit_in,
    // gpio data and direction, slot order addr, data, cs
    input  wire logic [ebps_pkg::NUM_PINS-1:0] gpio_out_in,
    input  wire logic [ebps_pkg::NUM_PINS-1:0] gpio_dir_in,
    // external memory interface side
    input  wire logic                         bus_active_in,
    input  wire logic                         address_line_twenty_in,
    input  wire logic [DATA_PINS-1:0]         data_wr_in,
    input  wire logic                         data_oe_in,
    input  wire logic [CS_PINS-1:0]           chip_select_in,
    input  wire logic                         prescaler_clock_in,
    // pads
    output logic [ebps_pkg::NUM_PINS-1:0]     pad_out,
    output logic [ebps_pkg::NUM_PINS-1:0]     pad_oe_out,
    output logic [ebps_pkg::NUM_PINS-1:0]     pad_pu_out,
    output logic [ebps_pkg::NUM_PINS-1:0]     periph_sel_out,
    output logic                              clock_output_select_out
);
    // ==========================================================
    // elaboration check
    // ==========================================================
    if (DATA_PINS != ebps_pkg::NUM_DATA || CS_PINS != ebps_pkg::NUM_CS)
        $error("ebps_pin_mux: pin counts must match the package");

    // ==========================================================
    // state
    // ==========================================================
    ebps_pkg::ebps_state_t s_q;
    ebps_pkg::ebps_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (port_b_pullup_wr_in)
            s_d.pu_addr = port_b_data_in[ebps_pkg::PORT_B_BIT];
        if (port_b_periph_wr_in)
            s_d.per_addr = port_b_data_in[ebps_pkg::PORT_B_BIT];
        if (port_f_pullup_wr_in)
            s_d.pu_data =
                port_f_data_in[ebps_pkg::PORT_F_BASE +: DATA_PINS];
        if (port_f_periph_wr_in)
            s_d.per_data = port_f_data_in[ebps_pkg::PORT_F_BASE +: DATA_PINS];
        if (port_d_pullup_wr_in)
            s_d.pu_cs =
                port_d_data_in[ebps_pkg::PORT_D_BASE +: CS_PINS];
        if (port_d_periph_wr_in)
            s_d.per_cs = port_d_data_in[ebps_pkg::PORT_D_BASE +: CS_PINS];
        if (clock_output_select_wr_in)
            s_d.clk_sel = clock_output_select_in;
    end

    always_ff @(posedge clk_sys_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q.pu_addr  <= ebps_pkg::RST_PU_ADDR;
            s_q.per_addr <= ebps_pkg::RST_PER_ADDR;
            s_q.pu_data  <= ebps_pkg::RST_PU_DATA;
            s_q.per_data <= ebps_pkg::RST_PER_DATA;
            s_q.pu_cs    <= ebps_pkg::RST_PU_CS;
            s_q.per_cs   <= ebps_pkg::RST_PER_CS;
            s_q.clk_sel  <= ebps_pkg::RST_CLK_SEL;
        end else if (clk_en_in) begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // peripheral drive
    // ==========================================================
    logic                              bus_drive;
    logic [ebps_pkg::NUM_PINS-1:0]     sel;
    logic [ebps_pkg::NUM_PINS-1:0]     p_out;
    logic [ebps_pkg::NUM_PINS-1:0]     p_oe;
    logic [ebps_pkg::NUM_PINS-1:0]     pu_en;

    // bus pins float while idle unless the drive bit holds them
    assign bus_drive = bus_active_in | bus_drive_control_bit_in;

    always_comb begin
        sel   = {s_q.per_cs, s_q.per_data, s_q.per_addr};
        pu_en = {s_q.pu_cs, s_q.pu_data, s_q.pu_addr};
        p_out[ebps_pkg::SLOT_ADDR] =
            s_q.clk_sel ? prescaler_clock_in : address_line_twenty_in;
        // the monitored clock is not a bus signal and drives continuously
        p_oe[ebps_pkg::SLOT_ADDR] = s_q.clk_sel | bus_drive;
        p_out[ebps_pkg::SLOT_DATA +: DATA_PINS] = data_wr_in;
        p_oe[ebps_pkg::SLOT_DATA +: DATA_PINS] =
            {DATA_PINS{data_oe_in & bus_drive}};
        p_out[ebps_pkg::SLOT_CS +: CS_PINS] = chip_select_in;
        p_oe[ebps_pkg::SLOT_CS +: CS_PINS] = {CS_PINS{bus_drive}};
    end

    // ==========================================================
    // pad cells
    // ==========================================================
    for (genvar i = 0; i < ebps_pkg::NUM_PINS; i++) begin : g_pad
        ebps_pad_cell u_pad (
            .periph_sel_in (sel[i]),
            .gpio_out_in   (gpio_out_in[i]),
            .gpio_dir_in   (gpio_dir_in[i]),
            .periph_out_in (p_out[i]),
            .periph_oe_in  (p_oe[i]),
            .pullup_en_in  (pu_en[i]),
            .pad_out       (pad_out[i]),
            .pad_oe_out    (pad_oe_out[i]),
            .pad_pu_out    (pad_pu_out[i])
        );
    end

    assign periph_sel_out          = sel;
    assign clock_output_select_out = s_q.clk_sel;

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    localparam int unsigned A = ebps_pkg::SLOT_ADDR;
    localparam int unsigned F = ebps_pkg::SLOT_DATA;
    localparam int unsigned D = ebps_pkg::SLOT_CS;

    AST_GPIO_MODE: assert property (
        !periph_sel_out[D] |-> pad_oe_out[D] == gpio_dir_in[D]
            && (!gpio_dir_in[D] || pad_out[D] == gpio_out_in[D]))
        else $error("gpio pin does not follow data and direction");

    AST_RESET_DEFAULTS: assert property (disable iff (1'b0)
        $fell(sys_rst_in) |-> !periph_sel_out[A] && s_q.pu_addr
            && &periph_sel_out[F +: DATA_PINS]
            && !(|periph_sel_out[D +: CS_PINS]) && &s_q.pu_cs)
        else $error("pin defaults wrong after reset");

    AST_B_PULLUP_OFF: assert property (
        clk_en_in && port_b_pullup_wr_in
            && !port_b_data_in[ebps_pkg::PORT_B_BIT]
            ##1 !port_b_pullup_wr_in [*2] |-> !pad_pu_out[A])
        else $error("address twenty pull-up still on");

    AST_B_PERIPH_ON: assert property (
        clk_en_in && port_b_periph_wr_in
            && port_b_data_in[ebps_pkg::PORT_B_BIT]
        |=> periph_sel_out[A])
        else $error("address twenty pin not handed to peripheral");

    AST_CLK_MONITOR: assert property (
        periph_sel_out[A] && clock_output_select_out
        |-> pad_oe_out[A] && pad_out[A] == prescaler_clock_in)
        else $error("prescaler clock not on pin");

    AST_ADDR_IDLE_FLOAT: assert property (
        periph_sel_out[A] && !clock_output_select_out && !bus_active_in
            && !bus_drive_control_bit_in |-> !pad_oe_out[A])
        else $error("address twenty driven on idle bus");

    AST_DATA_IDLE_FLOAT: assert property (
        &periph_sel_out[F +: DATA_PINS] && !bus_active_in
            && !bus_drive_control_bit_in |-> !(|pad_oe_out[F +: DATA_PINS]))
        else $error("data lines driven on idle bus");

    AST_F_PULLUP_OFF: assert property (
        clk_en_in && port_f_pullup_wr_in
            && !port_f_data_in[ebps_pkg::PORT_F_BASE]
        |=> !s_q.pu_data[0] && !pad_pu_out[F])
        else $error("port f pull-up still on");

    AST_CS_DRIVE: assert property (
        periph_sel_out[D] && (bus_active_in || bus_drive_control_bit_in)
        |-> pad_oe_out[D] && pad_out[D] == chip_select_in[0])
        else $error("chip select not driven");

    AST_D_PULLUP_OFF: assert property (
        clk_en_in && port_d_pullup_wr_in
            && !port_d_data_in[ebps_pkg::PORT_D_BASE]
        |=> !pad_pu_out[D])
        else $error("port d pull-up still on");

    AST_PERIPH_OWNS: assert property (
        periph_sel_out[F] |-> pad_out[F] == data_wr_in[0])
        else $error("gpio leaks into peripheral pin");

    AST_FREEZE: assert property (
        !clk_en_in |=> $stable(s_q))
        else $error("state moved while clock enable low");

    COV_CLK_MON: cover property (
        periph_sel_out[A] && clock_output_select_out);
    COV_ADDR_BUS: cover property (
        periph_sel_out[A] && bus_active_in && pad_oe_out[A]);
    COV_DATA_GPIO: cover property (
        !periph_sel_out[F] && gpio_dir_in[F]);
    COV_CS_IDLE: cover property (
        periph_sel_out[D] && !bus_active_in && !pad_oe_out[D]);
endmodule : ebps_pin_mux
`default_nettype wire

//--- sim/ebps_pad_model.sv
// behavioural pad wires seen by the external memory devices
`timescale 1ns/1ps
`default_nettype none
module ebps_pad_model (
    input  wire logic                          clk_in,
    input  wire logic [ebps_pkg::NUM_PINS-1:0] pad_in,
    input  wire logic [ebps_pkg::NUM_PINS-1:0] oe_in,
    input  wire logic [ebps_pkg::NUM_PINS-1:0] pu_in,
    output logic      [ebps_pkg::NUM_PINS-1:0] level_out
);
    // floating pins show a pattern that changes every cycle
    logic [ebps_pkg::NUM_PINS-1:0] float_q = '0;
    always_ff @(posedge clk_in) begin
        float_q <= ~float_q;
    end
    assign level_out = (oe_in & pad_in) | (~oe_in & pu_in)
                     | (~oe_in & ~pu_in & float_q);
endmodule : ebps_pad_model
`default_nettype wire

//--- sim/tb_top.sv
// random bench for the external bus pin sharing block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b, m) begin n_checks++; if ((a) !== (b)) begin \
    mismatches++; $display("CHECK FAILED t=%0t %s", $time, m); end end
module tb_top;
    localparam int unsigned N = ebps_pkg::NUM_PINS;
    logic clk_sys_in = 1'h0;
    logic sys_rst_in, clk_en_in, b_pu_wr, b_per_wr, f_pu_wr, f_per_wr;
    logic d_pu_wr, d_per_wr, cos_wr, cos, drv, act, doe, a20, pclk;
    logic [7:0] b_dat, f_dat, d_dat;
    logic [3:0] dwr;
    logic [5:0] cs;
    logic [N-1:0] gout, gdir, pad, oe, pu, sel, lvl;
    logic cosel;
    int seed = 32'h2910d86e;
    int mismatches = 0;
    int n_checks = 0;
    ebps_pkg::ebps_state_t s;
    always #10 clk_sys_in = ~clk_sys_in;
    ebps_pin_mux i_ebps_pin_mux (.clk_sys_in(clk_sys_in),
        .sys_rst_in(sys_rst_in), .clk_en_in(clk_en_in),
        .port_b_pullup_wr_in(b_pu_wr), .port_b_periph_wr_in(b_per_wr),
        .port_b_data_in(b_dat), .port_f_pullup_wr_in(f_pu_wr),
        .port_f_periph_wr_in(f_per_wr), .port_f_data_in(f_dat),
        .port_d_pullup_wr_in(d_pu_wr), .port_d_periph_wr_in(d_per_wr),
        .port_d_data_in(d_dat), .clock_output_select_wr_in(cos_wr),
        .clock_output_select_in(cos), .bus_drive_control_bit_in(drv),
        .gpio_out_in(gout), .gpio_dir_in(gdir), .bus_active_in(act),
        .address_line_twenty_in(a20), .data_wr_in(dwr), .data_oe_in(doe),
        .chip_select_in(cs), .prescaler_clock_in(pclk), .pad_out(pad),
        .pad_oe_out(oe), .pad_pu_out(pu), .periph_sel_out(sel),
        .clock_output_select_out(cosel));
    ebps_pad_model i_ebps_pad_model (.clk_in(clk_sys_in), .pad_in(pad),
        .oe_in(oe), .pu_in(pu), .level_out(lvl));
    // pick per slot the peripheral or the gpio value
    function automatic logic [N-1:0] exp_mux(input logic [N-1:0] sv,
        input logic [N-1:0] per, input logic [N-1:0] gp);
        return (sv & per) | (~sv & gp);
    endfunction : exp_mux
    // peripheral drive enables: chip selects, data lines, address slot
    function automatic logic [N-1:0] exp_per_oe(input logic po,
        input logic doe_i, input logic clk_sel_i);
        return {{ebps_pkg::NUM_CS{po}}, {ebps_pkg::NUM_DATA{doe_i & po}},
                clk_sel_i | po};
    endfunction : exp_per_oe
    // mode 0 holds reset, 1 runs free, 2 freezes the clock enable,
    // 3 keeps the bus idle with the drive bit off
    task automatic drive(input int mode);
        logic [95:0] r;
        r = {$random(seed), $random(seed), $random(seed)};
        // idle bus corner: clear the drive bit and bus active slots
        if (mode == 3) r[60:59] = 2'h0;
        {b_pu_wr, b_per_wr, f_pu_wr, f_per_wr, d_pu_wr, d_per_wr, cos_wr,
         cos, drv, act, doe, a20, pclk, b_dat, f_dat, d_dat, gout, gdir,
         dwr, cs} = r[68:0];
        sys_rst_in = (mode == 0) || (mode == 1 && r[95:91] == 5'h00);
        clk_en_in = (mode != 2) && (r[90:89] != 2'h0);
    endtask : drive
    // mirror of the registers as they should stand after the last edge
    task automatic update();
        if (sys_rst_in) begin
            s = {ebps_pkg::RST_PU_ADDR, ebps_pkg::RST_PER_ADDR,
                 ebps_pkg::RST_PU_DATA, ebps_pkg::RST_PER_DATA,
                 ebps_pkg::RST_PU_CS, ebps_pkg::RST_PER_CS,
                 ebps_pkg::RST_CLK_SEL};
        end else if (clk_en_in) begin
            if (b_pu_wr) s.pu_addr = b_dat[ebps_pkg::PORT_B_BIT];
            if (b_per_wr) s.per_addr = b_dat[ebps_pkg::PORT_B_BIT];
            if (f_pu_wr) s.pu_data = f_dat[3:0];
            if (f_per_wr) s.per_data = f_dat[3:0];
            if (d_pu_wr) s.pu_cs = d_dat[5:0];
            if (d_per_wr) s.per_cs = d_dat[5:0];
            if (cos_wr) s.clk_sel = cos;
        end
    endtask : update
    task automatic check();
        logic [N-1:0] sv, eo, ev, ep;
        sv = {s.per_cs, s.per_data, s.per_addr};
        eo = exp_mux(sv, exp_per_oe(act | drv, doe, s.clk_sel), gdir);
        ev = exp_mux(sv, {cs, dwr, s.clk_sel ? pclk : a20}, gout);
        ep = {s.pu_cs, s.pu_data, s.pu_addr} & ~eo;
        `CHK(sel, sv, "peripheral select")
        `CHK(cosel, s.clk_sel, "clock select")
        `CHK(oe, eo, "output enable")
        `CHK(pad & eo, ev & eo, "pad value")
        `CHK(pu, ep, "pull-up")
        `CHK(lvl & (eo | ep), (ev & eo) | ep, "pin level")
    endtask : check
    task automatic run(input int mode, input int cycles, input string name);
        repeat (cycles) begin
            @(negedge clk_sys_in);
            update();
            check();
            drive(mode);
        end
        $display("test %s done", name);
    endtask : run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : tally_and_finish
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        drive(0);
        run(0, 4, "reset defaults");
        run(1, 1500, "random traffic");
        run(2, 20, "frozen writes");
        run(3, 200, "idle bus float");
        run(0, 2, "second reset");
        run(1, 1500, "random after reset");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
